// ===== bench/ast_rx_model.sv
// Purpose: remote receiver model that samples the serial line mid-bit
// Assumes: bit period in mclk cycles is given by the bench
// Notes:   passive; it records characters, frame checks and start cycles
`timescale 1ns/100ps
module ast_rx_model (
    input wire logic mclk,   // system clock
    input wire logic line,   // serial line level
    input var  int   bitCyc, // cycles per bit
    input wire logic nine,   // nine data bits
    input wire logic inv,    // line inverted
    input wire logic listen  // hunting for start bits
);
    logic [8:0] rxChar[$];
    logic       rxOk[$];
    int         rxAt[$];
    int         cyc = 0;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end

    // listen is dropped by the bench while it reconfigures, to avoid false starts
    initial forever begin
        logic [8:0] c;
        logic       ok;
        @(posedge mclk);
        if (listen && (line ^ inv) === 1'b0) begin
            rxAt.push_back(cyc);
            repeat (bitCyc / 2) @(posedge mclk);
            ok = ((line ^ inv) === 1'b0);
            c = 9'h000;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (bitCyc) @(posedge mclk);
                c[i] = line ^ inv;
            end
            repeat (bitCyc) @(posedge mclk);
            ok = ok && ((line ^ inv) === 1'b1);
            rxChar.push_back(c);
            rxOk.push_back(ok);
        end
    end
endmodule : ast_rx_model

// ===== bench/test_async_serial_transmitter.sv
// Purpose: self-checking bench for the asynchronous serial transmitter
// Assumes: zero-wait register port, one mclk per instruction cycle
// Notes:   frames are judged by the receiver model on the line
`timescale 1ns/100ps
module test_async_serial_transmitter;
    localparam logic [31:0] TRANSMITTER_ENABLE_BIT = 32'h0000_0001 << ast_pkg::CTRL_TRANSMITTER_ENABLE_BIT;
    localparam logic [31:0] PEN  = 32'h0000_0001 << ast_pkg::CTRL_PORTEN;
    localparam logic [31:0] EN   = TRANSMITTER_ENABLE_BIT | PEN;
    localparam logic [31:0] SYNC = 32'h0000_0001 << ast_pkg::CTRL_SYNC;
    localparam logic [31:0] INV  = 32'h0000_0001 << ast_pkg::CTRL_POLINV;
    localparam logic [31:0] NINE = 32'h0000_0001 << ast_pkg::CTRL_NINE;
    localparam logic [31:0] B16  = 32'h0000_0001 << ast_pkg::CTRL_BRG16;
    localparam logic [31:0] IRQ  = 32'h0000_0001 << ast_pkg::CTRL_IRQEN;

    logic        mclk   = 1'b0;
    logic        srst   = 1'b1;
    logic        hsel   = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize  = ast_pkg::HSIZE_WORD;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic        nine   = 1'b0;
    logic        inv    = 1'b0;
    logic        listen = 1'b0;
    int          bitCyc = 4;
    int          error_cnt = 0;
    int          cmp_count = 0;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         txPinOut;
    wire         txPinOe;
    wire         txIrqReq;

    always #50 mclk = ~mclk;

    ast_transmitter dut (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .txPinOut(txPinOut), .txPinOe(txPinOe), .txIrqReq(txIrqReq));
    ast_rx_model rx (.mclk(mclk), .line(txPinOut), .bitCyc(bitCyc), .nine(nine),
        .inv(inv), .listen(listen));

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            summarize();
        end
    endtask : waitRdy

    // entered just after a rising edge; read data lands in rd
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {20'h0_0000, a};
        hwrite <= wr;
        waitRdy();
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
    endtask : bus

    task automatic waitRx(input int n);
        int k;
        k = 0;
        while (rx.rxChar.size() < n && k < 6000) begin
            @(posedge mclk);
            k++;
        end
        if (rx.rxChar.size() < n) begin
            error_cnt++;
            summarize();
        end
    endtask : waitRx

    task automatic cfg(input logic [31:0] ctrl, input logic [31:0] baud, input int cyc);
        listen <= 1'b0;
        bus(1'b1, ast_pkg::OFF_BAUD, baud);
        bus(1'b1, ast_pkg::OFF_CTRL, ctrl);
        repeat (3) @(posedge mclk);
        bitCyc <= cyc;
        nine   <= ctrl[ast_pkg::CTRL_NINE];
        inv    <= ctrl[ast_pkg::CTRL_POLINV] && !ctrl[ast_pkg::CTRL_SYNC];
        listen <= 1'b1;
        @(posedge mclk);
    endtask : cfg

    task automatic sendOne(input logic [31:0] ch, input logic [8:0] exp);
        int n;
        n = rx.rxChar.size();
        bus(1'b1, ast_pkg::OFF_DATA, ch);
        waitRx(n + 1);
        chk("char", 32'(exp), 32'(rx.rxChar[n]));
        chk("frame", 32'h0000_0001, 32'(rx.rxOk[n]));
        repeat (bitCyc) @(posedge mclk);
    endtask : sendOne

    task automatic tReset();
        chk("idle line", 32'h0000_0001, 32'(txPinOut));
        chk("pin enable", 32'h0000_0000, 32'(txPinOe));
        chk("hresp", 32'h0000_0000, 32'(hresp));
        bus(1'b0, ast_pkg::OFF_CTRL, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0000, rd);
    endtask : tReset

    task automatic tBasic();
        cfg(EN, 32'h0000_0003, 4);
        chk("pin enable", 32'h0000_0001, 32'(txPinOe));
        bus(1'b0, ast_pkg::OFF_STATUS, 32'h0000_0000);
        chk("empty flag", 32'h0000_0001, rd);
        sendOne(32'h0000_01A5, 9'h0A5);
        sendOne(32'h0000_0000, 9'h000);
        bus(1'b1, ast_pkg::OFF_STATUS, 32'h0000_0000);
        bus(1'b0, ast_pkg::OFF_STATUS, 32'h0000_0000);
        chk("flag after write", 32'h0000_0001, rd);
        bus(1'b0, 12'h010, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        bus(1'b0, ast_pkg::OFF_DATA, 32'h0000_0000);
        chk("data read", 32'h0000_0000, rd);
        hsize <= 3'h0;
        bus(1'b1, ast_pkg::OFF_BAUD, 32'h0000_00FF);
        hsize <= ast_pkg::HSIZE_WORD;
        bus(1'b0, ast_pkg::OFF_BAUD, 32'h0000_0000);
        chk("narrow write", 32'h0000_0003, rd);
    endtask : tBasic

    // second character queues behind the first and follows it with no idle time
    task automatic tQueue();
        int n;
        cfg(EN | IRQ, 32'h0000_0003, 4);
        repeat (3) @(posedge mclk);
        chk("irq request", 32'h0000_0001, 32'(txIrqReq));
        n = rx.rxChar.size();
        bus(1'b1, ast_pkg::OFF_DATA, 32'h0000_0055);
        bus(1'b1, ast_pkg::OFF_DATA, 32'h0000_00C3);
        repeat (2) @(posedge mclk);
        bus(1'b0, ast_pkg::OFF_STATUS, 32'h0000_0000);
        chk("queued flag", 32'h0000_0000, 32'(rd[ast_pkg::STAT_EMPTY]));
        chk("irq queued", 32'h0000_0000, 32'(txIrqReq));
        bus(1'b1, ast_pkg::OFF_CTRL, EN);
        waitRx(n + 2);
        chk("first", 32'h0000_0055, 32'(rx.rxChar[n]));
        chk("second", 32'h0000_00C3, 32'(rx.rxChar[n + 1]));
        chk("gap", 32'(10 * bitCyc), 32'(rx.rxAt[n + 1] - rx.rxAt[n]));
        repeat (bitCyc) @(posedge mclk);
        bus(1'b0, ast_pkg::OFF_STATUS, 32'h0000_0000);
        chk("drained flag", 32'h0000_0001, 32'(rd[ast_pkg::STAT_EMPTY]));
        chk("irq masked", 32'h0000_0000, 32'(txIrqReq));
    endtask : tQueue

    task automatic tFormats();
        cfg(EN | NINE, 32'h0000_0003, 4);
        sendOne(32'h0000_013C, 9'h13C);
        sendOne(32'h0000_003C, 9'h03C);
        cfg(EN | INV, 32'h0000_0003, 4);
        chk("inverted idle", 32'h0000_0000, 32'(txPinOut));
        sendOne(32'h0000_0096, 9'h096);
        cfg(EN, 32'h0000_0102, 3);
        sendOne(32'h0000_005A, 9'h05A);
        cfg(EN | B16, 32'h0000_0102, 259);
        sendOne(32'h0000_00A6, 9'h0A6);
    endtask : tFormats

    task automatic tQualify();
        logic [31:0] bad[4];
        int          n;
        bad = '{PEN, TRANSMITTER_ENABLE_BIT, EN | SYNC, EN | SYNC | INV};
        foreach (bad[i]) begin
            cfg(bad[i], 32'h0000_0003, 4);
            n = rx.rxChar.size();
            bus(1'b1, ast_pkg::OFF_DATA, 32'h0000_0000);
            repeat (60) @(posedge mclk);
            chk("no frame", 32'(n), 32'(rx.rxChar.size()));
            chk("held mark", 32'h0000_0001, 32'(txPinOut));
        end
        cfg(EN, 32'h0000_0003, 4);
        listen <= 1'b0;
        bus(1'b1, ast_pkg::OFF_DATA, 32'h0000_0000);
        repeat (8) @(posedge mclk);
        bus(1'b1, ast_pkg::OFF_CTRL, PEN);
        repeat (3) @(posedge mclk);
        chk("abort mark", 32'h0000_0001, 32'(txPinOut));
    endtask : tQualify

    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        tReset();
        tBasic();
        tQueue();
        tFormats();
        tQualify();
        summarize();
    end
endmodule : test_async_serial_transmitter

// ===== hw/ast_pkg.sv
// Purpose: shared constants and types for the asynchronous serial transmitter
// Assumes: 32-bit AHB-Lite register port, one word per register
// Notes:   offsets are byte addresses within the block's window
package ast_pkg;

    // register byte offsets (low address bits decoded)
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_DATA   = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_BAUD   = 12'h00C;
    localparam int          DEC_W      = 12;

    // control word field positions
    localparam int CTRL_TRANSMITTER_ENABLE_BIT   = 0;
    localparam int CTRL_SYNC   = 1;
    localparam int CTRL_PORTEN = 2;
    localparam int CTRL_POLINV = 3;
    localparam int CTRL_NINE   = 4;
    localparam int CTRL_BRG16  = 5;
    localparam int CTRL_IRQEN  = 6;
    localparam int CTRL_W      = 7;

    // data word: bits 7:0 character, bit 8 software ninth bit
    localparam int DATA_NINTH  = 8;
    localparam int CHAR_W      = 9;

    // status word field positions
    localparam int STAT_EMPTY  = 0;
    localparam int STAT_BUSY   = 1;
    localparam int STAT_IRQ    = 2;

    localparam int BAUD_W      = 16;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0000;

    // hsize code of a whole word, htrans bit meaning "transfer present"
    localparam logic [2:0] HSIZE_WORD  = 3'h2;
    localparam int         HTRANS_ACT  = 1;

    // frame shape
    localparam logic [3:0] LAST_IDX8 = 4'h7;
    localparam logic [3:0] LAST_IDX9 = 4'h8;

    typedef struct packed {
        logic irqEnable;
        logic brg16;
        logic nineBit;
        logic polInvert;
        logic portEnable;
        logic syncMode;
        logic txEnable;
    } ast_ctrl_t;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } ast_char_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } ast_state_t;

endpackage : ast_pkg

// ===== hw/ast_transmitter.sv
// Purpose: asynchronous NRZ transmitter with holding buffer and baud generator
// Assumes: mclk 10 MHz, one instruction cycle equals one mclk cycle
// Notes:   zero-wait AHB-Lite slave, responses always OKAY
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps

// Behaviour
// [R01] line idles at mark when not sending
// [R02] frame: start, eight/nine data, stop
// [R03] start bit space, stop bits mark
// [R04] every bit lasts one baud period
// [R05] baud divider selectable 8 or 16 bit
// [R06] data shifted least significant bit first
// [R07] ninth bit sent as written, no parity
// [R08] shifter loaded only from holding buffer
// [R09] runs only enabled, asynchronous, port enabled
// [R10] port enable drives the pin as output
// [R11] buffer write starts; empty shifter loads immediately
// [R12] queued character waits for current stop bit
// [R13] queued character loads right after stop bit
// [R14] polarity bit resets zero, inverts all
// [R15] polarity acts only in asynchronous mode
// [R16] empty flag set unless busy and queued; code also holds it clear while txEnable is low
// [R17] flag reflects write from second cycle
// [R18] empty flag is read-only to software
// [R19] flag independent of enable; enable gates request
// [R20] software enables interrupt only while data remains
// [R21] eight-bit frame has one stop bit
module ast_transmitter (
    input  wire logic        mclk,      // system clock
    input  wire logic        srst,      // synchronous reset, active high
    input  wire logic        hsel,      // slave select
    input  wire logic [31:0] haddr,     // byte address
    input  wire logic [1:0]  htrans,    // transfer type
    input  wire logic        hwrite,    // write when high
    input  wire logic [2:0]  hsize,     // transfer size
    input  wire logic [31:0] hwdata,    // write data
    input  wire logic        hready,    // bus ready in
    output logic      [31:0] hrdata,    // read data
    output logic             hreadyout, // slave ready
    output logic             hresp,     // always OKAY
    output logic             txPinOut,  // serial line level
    output logic             txPinOe,   // line output enable
    output logic             txIrqReq   // gated buffer-empty request
);

    ast_pkg::ast_ctrl_t              ctrlFf;
    logic [ast_pkg::BAUD_W-1:0]      baudDivFf;
    ast_pkg::ast_char_t              holdFf;
    logic                            holdFullFf;
    logic [ast_pkg::CHAR_W-1:0]      shiftFf;
    ast_pkg::ast_state_t             stateFf;
    logic [3:0]                      bitIdxFf;
    logic                            frameNineFf;
    logic [ast_pkg::BAUD_W-1:0]      frameDivFf;
    logic [ast_pkg::BAUD_W-1:0]      baudCntFf;
    logic                            flagFf;
    logic                            irqReqFf;
    logic                            pinOutFf;
    logic                            pinOeFf;
    logic [31:0]                     hrdataFf;
    logic                            hreadyoutFf;
    logic                            wrPendFf;
    logic [ast_pkg::DEC_W-1:0]       wrAddrFf;

    logic                            addrPhase;
    logic                            dataWrite;
    logic                            ctrlWrite;
    logic                            baudWrite;
    logic                            operating;
    logic                            invEff;
    logic [ast_pkg::BAUD_W-1:0]      effDiv;
    logic                            bitEnd;
    logic                            lastBit;
    logic                            loadShift;
    logic                            lineBit;
    logic [3:0]                      lastIdx;
    logic [31:0]                     nxt_rdata;

    // bus decode
    assign addrPhase = hsel && htrans[ast_pkg::HTRANS_ACT] && hready;
    assign dataWrite = wrPendFf && (wrAddrFf == ast_pkg::OFF_DATA);
    assign ctrlWrite = wrPendFf && (wrAddrFf == ast_pkg::OFF_CTRL);
    assign baudWrite = wrPendFf && (wrAddrFf == ast_pkg::OFF_BAUD);

    // transmitter qualification
    assign operating = ctrlFf.txEnable && !ctrlFf.syncMode && ctrlFf.portEnable; // [R09]
    assign invEff    = ctrlFf.polInvert && !ctrlFf.syncMode;                     // [R15]
    assign effDiv    = ctrlFf.brg16 ? baudDivFf
                                    : {8'h00, baudDivFf[7:0]};                   // [R05]

    assign bitEnd    = (stateFf != ast_pkg::ST_IDLE) && (baudCntFf == 16'h0000);
    assign lastIdx   = frameNineFf ? ast_pkg::LAST_IDX9 : ast_pkg::LAST_IDX8;  // [R21]
    assign lastBit   = (bitIdxFf == lastIdx);

    // load when idle, or straight off the end of a stop bit so no gap appears
    assign loadShift = operating && holdFullFf &&
                       ((stateFf == ast_pkg::ST_IDLE) ||
                        (stateFf == ast_pkg::ST_STOP && bitEnd));                // [R11] [R13]

    always_comb begin
        case (stateFf)
            ast_pkg::ST_IDLE:  lineBit = 1'b1;        // [R01]
            ast_pkg::ST_START: lineBit = 1'b0;        // [R03]
            ast_pkg::ST_DATA:  lineBit = shiftFf[0];  // [R06] [R07]
            ast_pkg::ST_STOP:  lineBit = 1'b1;        // [R03]
            default:           lineBit = 1'b1;
        endcase
    end

    // read mux, sampled in the address phase so data stands in the data phase
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (haddr[ast_pkg::DEC_W-1:0])
            ast_pkg::OFF_CTRL:   nxt_rdata[ast_pkg::CTRL_W-1:0] = ctrlFf;
            ast_pkg::OFF_BAUD:   nxt_rdata[ast_pkg::BAUD_W-1:0] = baudDivFf;
            ast_pkg::OFF_STATUS: begin
                nxt_rdata[ast_pkg::STAT_EMPTY] = flagFf;
                nxt_rdata[ast_pkg::STAT_BUSY]  = (stateFf != ast_pkg::ST_IDLE);
                nxt_rdata[ast_pkg::STAT_IRQ]   = irqReqFf;
            end
            // holding buffer is write-only; shifter is never visible
            default:             nxt_rdata = 32'h0000_0000;               // [R08]
        endcase
    end

    // bus slave
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrPendFf    <= 1'b0;
            wrAddrFf    <= 12'h000;
            hrdataFf    <= 32'h0000_0000;
            hreadyoutFf <= 1'b1;
        end else begin
            hreadyoutFf <= 1'b1;
            wrPendFf    <= addrPhase && hwrite && (hsize == ast_pkg::HSIZE_WORD);
            wrAddrFf    <= haddr[ast_pkg::DEC_W-1:0];
            if (addrPhase && !hwrite) begin
                hrdataFf <= nxt_rdata;
            end
        end
    end

    // configuration registers; status has no write path at all
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrlFf    <= ast_pkg::CTRL_RST;                               // [R14]
            baudDivFf <= ast_pkg::BAUD_RST;
        end else begin
            if (ctrlWrite) begin
                ctrlFf <= hwdata[ast_pkg::CTRL_W-1:0];
            end
            if (baudWrite) begin
                baudDivFf <= hwdata[ast_pkg::BAUD_W-1:0];
            end
        end
    end

    // holding buffer; a write in the load cycle refills it, so nothing is lost
    always_ff @(posedge mclk) begin
        if (srst) begin
            holdFf     <= '0;
            holdFullFf <= 1'b0;
        end else if (!operating) begin
            holdFullFf <= 1'b0;
        end else if (dataWrite) begin
            holdFf     <= hwdata[ast_pkg::CHAR_W-1:0];                   // [R11]
            holdFullFf <= 1'b1;                                          // [R12]
        end else if (loadShift) begin
            holdFullFf <= 1'b0;
        end
    end

    // frame sequencer
    always_ff @(posedge mclk) begin
        if (srst) begin
            stateFf     <= ast_pkg::ST_IDLE;
            shiftFf     <= '0;
            bitIdxFf    <= 4'h0;
            frameNineFf <= 1'b0;
            frameDivFf  <= 16'h0000;
            baudCntFf   <= 16'h0000;
        end else if (!operating) begin
            stateFf   <= ast_pkg::ST_IDLE;                               // [R09]
            baudCntFf <= 16'h0000;
        end else if (loadShift) begin
            shiftFf     <= holdFf;                                       // [R08]
            frameNineFf <= ctrlFf.nineBit;
            frameDivFf  <= effDiv;
            baudCntFf   <= effDiv;                                       // [R04]
            bitIdxFf    <= 4'h0;
            stateFf     <= ast_pkg::ST_START;                            // [R13]
        end else if (stateFf == ast_pkg::ST_IDLE) begin
            baudCntFf <= 16'h0000;
        end else if (!bitEnd) begin
            baudCntFf <= baudCntFf - 16'h0001;
        end else begin
            baudCntFf <= frameDivFf;                                     // [R04]
            case (stateFf)
                ast_pkg::ST_START: begin
                    stateFf <= ast_pkg::ST_DATA;
                end
                ast_pkg::ST_DATA: begin
                    shiftFf  <= {1'b0, shiftFf[ast_pkg::CHAR_W-1:1]};   // [R06]
                    bitIdxFf <= bitIdxFf + 4'h1;
                    if (lastBit) begin
                        stateFf <= ast_pkg::ST_STOP;                     // [R02] [R21]
                    end
                end
                ast_pkg::ST_STOP: begin
                    stateFf <= ast_pkg::ST_IDLE;
                end
                default: begin
                    stateFf <= ast_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // empty flag lags the buffer by one edge, which gives the second-cycle timing
    always_ff @(posedge mclk) begin
        if (srst) begin
            flagFf   <= 1'b0;
            irqReqFf <= 1'b0;
        end else begin
            flagFf   <= ctrlFf.txEnable && !holdFullFf;                  // [R16] [R17] [R18]
            irqReqFf <= flagFf && ctrlFf.irqEnable;                      // [R19]
        end
    end

    // pin; idles at mark (inverted when asked, except in synchronous mode) even while disabled
    always_ff @(posedge mclk) begin
        if (srst) begin
            pinOutFf <= 1'b1;
            pinOeFf  <= 1'b0;
        end else begin
            pinOutFf <= lineBit ^ invEff;                                // [R14]
            pinOeFf  <= ctrlFf.portEnable;                               // [R10]
        end
    end

    assign hrdata    = hrdataFf;
    assign hreadyout = hreadyoutFf;
    assign hresp     = 1'b0;
    assign txPinOut  = pinOutFf;
    assign txPinOe   = pinOeFf;
    assign txIrqReq  = irqReqFf;

    // cycles spent in the current bit, only for checking
    logic [ast_pkg::BAUD_W-1:0] bitCycFf;
    always_ff @(posedge mclk) begin
        if (srst || loadShift || bitEnd || stateFf == ast_pkg::ST_IDLE) begin
            bitCycFf <= 16'h0000;
        end else begin
            bitCycFf <= bitCycFf + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence queuedAtStopEnd;
        operating && stateFf == ast_pkg::ST_STOP && bitEnd && holdFullFf && !dataWrite;
    endsequence

    sequence freshStart;
        stateFf == ast_pkg::ST_START && !holdFullFf;
    endsequence

    sequence bufferFilled;
        $rose(holdFullFf) && ctrlFf.txEnable && $stable(ctrlFf.txEnable);
    endsequence

    idle_mark_a: assert property ( // [R01]
        (stateFf == ast_pkg::ST_IDLE && !invEff) |=> txPinOut)
        else $error("line not at mark while idle");

    start_space_a: assert property ( // [R03]
        (stateFf == ast_pkg::ST_START && !invEff) |=> !txPinOut)
        else $error("start bit not at space");

    stop_mark_a: assert property ( // [R03]
        (stateFf == ast_pkg::ST_STOP && $stable(ctrlFf)) |=> txPinOut == !$past(invEff))
        else $error("stop bit not at mark");

    bit_period_a: assert property ( // [R04]
        bitEnd |-> bitCycFf == frameDivFf)
        else $error("bit held for wrong number of cycles");

    lsb_first_a: assert property ( // [R06]
        (stateFf == ast_pkg::ST_START && bitEnd && operating && !loadShift)
        |=> lineBit == $past(shiftFf[0]) ##1 (stateFf == ast_pkg::ST_DATA))
        else $error("first data bit is not the lsb");

    frame_len_a: assert property ( // [R02]
        (stateFf == ast_pkg::ST_DATA && bitEnd && operating)
        |=> stateFf == (($past(lastBit)) ? ast_pkg::ST_STOP : ast_pkg::ST_DATA))
        else $error("wrong number of data bits");

    hold_wait_a: assert property ( // [R12]
        (operating && holdFullFf && stateFf != ast_pkg::ST_IDLE && !bitEnd)
        |=> holdFullFf && !$rose(stateFf == ast_pkg::ST_START))
        else $error("queued character left buffer before stop end");

    back_to_back_a: assert property ( // [R13]
        queuedAtStopEnd |=> freshStart)
        else $error("queued character not loaded after stop bit");

    flag_delay_a: assert property ( // [R17]
        bufferFilled |-> flagFf ##1 (!flagFf || !holdFullFf))
        else $error("empty flag changed too early or not at all");

    flag_set_a: assert property ( // [R16]
        (ctrlFf.txEnable && !holdFullFf) |=> flagFf)
        else $error("empty flag clear with empty buffer");

    irq_gate_a: assert property ( // [R19]
        (!ctrlFf.irqEnable && $stable(ctrlFf.irqEnable)) |=> !txIrqReq)
        else $error("request raised while disabled");

    run_enable_a: assert property ( // [R09]
        !operating |=> stateFf == ast_pkg::ST_IDLE && !holdFullFf)
        else $error("transmitter active while not qualified");

    pin_drive_a: assert property ( // [R10]
        ctrlFf.portEnable |=> txPinOe)
        else $error("pin not driven with port enabled");

    pin_release_a: assert property ( // [R10]
        !ctrlFf.portEnable |=> !txPinOe)
        else $error("pin driven with port disabled");

    // the flag may only drop while a character waits in the buffer
    empty_clear_a: assert property ( // [R16]
        (!flagFf && ctrlFf.txEnable && $stable(ctrlFf.txEnable)) |-> $past(holdFullFf))
        else $error("empty flag clear with nothing queued");

    irq_raise_a: assert property ( // [R19]
        (flagFf && ctrlFf.irqEnable) |=> txIrqReq)
        else $error("request missing with flag and enable set");

    inv_idle_a: assert property ( // [R14]
        (stateFf == ast_pkg::ST_IDLE && invEff) |=> !txPinOut)
        else $error("inverted line not idling low");

    sync_polarity_a: assert property ( // [R15]
        (stateFf == ast_pkg::ST_IDLE && ctrlFf.syncMode) |=> txPinOut)
        else $error("polarity applied outside asynchronous mode");

    // a write into an empty buffer with an idle shifter fills it on the next edge and loads the shifter on the edge after
    sequence loadFromIdle;
        stateFf == ast_pkg::ST_IDLE && holdFullFf ##1 stateFf == ast_pkg::ST_START;
    endsequence

    empty_load_a: assert property ( // [R11]
        (operating && stateFf == ast_pkg::ST_IDLE && !holdFullFf && dataWrite)
        |=> loadFromIdle)
        else $error("idle shifter did not take the written character");

    shift_load_a: assert property ( // [R08]
        loadShift |=> shiftFf == $past(holdFf))
        else $error("shifter loaded from somewhere other than the buffer");

    start_data_a: assert property ( // [R02]
        (stateFf == ast_pkg::ST_START && bitEnd && operating)
        |=> stateFf == ast_pkg::ST_DATA && bitIdxFf == 4'h0)
        else $error("start bit not followed by the first data bit");

    data_index_a: assert property ( // [R02]
        stateFf == ast_pkg::ST_DATA |-> bitIdxFf <= lastIdx)
        else $error("data bit count beyond the frame format");

    single_stop_a: assert property ( // [R21]
        (stateFf == ast_pkg::ST_STOP && bitEnd && operating && !holdFullFf)
        |=> stateFf == ast_pkg::ST_IDLE)
        else $error("more than one stop bit sent");

    // a baud write mid-frame must wait for the next character
    div_latch_a: assert property ( // [R04]
        (stateFf != ast_pkg::ST_IDLE && operating && !loadShift) |=> $stable(frameDivFf))
        else $error("bit period changed inside a frame");

endmodule : ast_transmitter
